/* pkg/embc_pkg.sv */
//
// Behaviour
// - clock output is half oscillator, even duty
// - outside reset realigns clock, starts ten-state sequence
// - reset pin is input and open-drain output
// - width input picks width when config bit1 set
// - config bit1 clear forces 8-bit cycles
// - fetch kind high for fetch, external only
// - 2000H-3FFFH internal when access select high
// - config picks latch strobe or valid form
// - address strobe only during external accesses
// - read strobe only on external reads
// - plain write strobe low every external write
// - low-byte write strobe only even byte writes
// - high-byte enable low on odd-byte or 16-bit word writes
// - high-byte write strobe only odd byte writes
// - ready low stretches cycle until ready high
// - ready ignored outside external cycles
// - config sets internal wait state count
package embc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] EMBC_CFG_OFS    = 12'h000;
  localparam logic [11:0] EMBC_STAT_OFS   = 12'h004;
  localparam logic [11:0] EMBC_REQ_OFS    = 12'h008;
  localparam logic [11:0] EMBC_ADDR_OFS   = 12'h00C;
  localparam logic [11:0] EMBC_WDATA_OFS  = 12'h010;
  localparam logic [11:0] EMBC_RDATA_OFS  = 12'h014;
  // chip_config_setting fields
  localparam int EMBC_CFG_ADV_BIT  = 0;
  localparam int EMBC_CFG_BW_BIT   = 1;
  localparam int EMBC_CFG_WRL_BIT  = 2;
  localparam int EMBC_CFG_WRH_BIT  = 3;
  localparam int EMBC_CFG_WS_LSB   = 4;
  localparam logic [31:0] EMBC_CFG_RST = 32'h0000_0000;
  // request fields
  localparam int EMBC_REQ_WR_BIT   = 0;
  localparam int EMBC_REQ_FETCH_BIT = 1;
  localparam int EMBC_REQ_WORD_BIT = 2;
  // memory region routed by external_access_select
  localparam logic [15:0] EMBC_INT_LO = 16'h2000;
  localparam logic [15:0] EMBC_INT_HI = 16'h3FFF;
  // timing in state times
  localparam int EMBC_RST_IN_STATES  = 4;
  localparam int EMBC_RST_SEQ_STATES = 10;
  localparam int EMBC_STATE_CYC      = 2;
  localparam logic [4:0] EMBC_RST_SEQ_CYC = 5'(EMBC_RST_SEQ_STATES * EMBC_STATE_CYC);
  localparam logic [3:0] EMBC_RST_IN_CYC  = 4'(EMBC_RST_IN_STATES * EMBC_STATE_CYC);

  typedef enum logic [2:0] {
    EMBC_IDLE = 3'b000,
    EMBC_ADR  = 3'b001,
    EMBC_WS   = 3'b010,
    EMBC_DATA = 3'b011,
    EMBC_RDY  = 3'b100,
    EMBC_END  = 3'b101
  } embc_state_e;

  function automatic logic embc_is_internal(input logic [15:0] a, input logic ea);
    embc_is_internal = ea && (a >= EMBC_INT_LO) && (a <= EMBC_INT_HI);
  endfunction : embc_is_internal
endpackage : embc_pkg

/* pkg/embc_req_if.sv */
`timescale 1ns/1ns
interface embc_req_if;
  logic        start;
  logic        wr;
  logic        fetch;
  logic        word;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        busy;
  logic        internal;
  modport ctl (output start, wr, fetch, word, addr, wdata, input rdata, busy, internal);
  modport seq (input start, wr, fetch, word, addr, wdata, output rdata, busy, internal);
endinterface : embc_req_if

/* core/embc_cycle.sv */
`timescale 1ns/1ns
module embc_cycle
  import embc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        run,
  input  wire logic        phase,
  input  wire logic [31:0] cfg,
  input  wire logic        ready_s,
  input  wire logic        width_s,
  input  wire logic        ext_sel_s,
  input  wire logic [15:0] ad_in,
  embc_req_if.seq          rq,
  output logic [15:0]      ad_out,
  output logic [15:0]      ad_oe,
  output logic             addr_strobe,
  output logic             read_n,
  output logic             write_n,
  output logic             high_n,
  output logic             fetch_kind_output
);
  embc_state_e st_q;
  logic [3:0]  ws_q;
  logic        ext_q;
  logic        w16_q;
  logic [15:0] rd_q;
  logic        ad_odd;
  logic        use_lo;
  logic        use_hi;

  // ---------------------------------------------------------------
  // bus cycle sequencer, one state per clock_output period
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= EMBC_IDLE;
      ws_q  <= 4'h0;
      ext_q <= 1'b0;
      w16_q <= 1'b0;
      rd_q  <= 16'h0000;
    end else if (ce && phase) begin
      case (st_q)
        EMBC_IDLE: begin
          if (run && rq.start) begin
            ext_q <= !embc_is_internal(rq.addr, ext_sel_s);
            st_q  <= EMBC_ADR;
            ws_q  <= cfg[EMBC_CFG_WS_LSB +: 4];
          end
        end
        EMBC_ADR: begin
          w16_q <= cfg[EMBC_CFG_BW_BIT] && width_s;
          st_q  <= (ws_q != 4'h0) ? EMBC_WS : EMBC_DATA;
        end
        EMBC_WS: begin
          ws_q <= ws_q - 4'h1;
          if (ws_q == 4'h1) begin
            st_q <= EMBC_DATA;
          end
        end
        EMBC_DATA: begin
          st_q <= (ext_q && !ready_s) ? EMBC_RDY : EMBC_END;
        end
        EMBC_RDY: begin
          if (ready_s) begin
            st_q <= EMBC_END;
          end
        end
        EMBC_END: begin
          if (!rq.wr) begin
            rd_q <= ext_q ? ad_in : 16'hFFFF;
          end
          st_q <= EMBC_IDLE;
        end
        default: st_q <= EMBC_IDLE;
      endcase
    end
  end

  assign ad_odd = rq.addr[0];
  assign use_lo = !ad_odd;
  assign use_hi = ad_odd || (rq.word && w16_q);
  assign rq.busy = (st_q != EMBC_IDLE);
  assign rq.internal = !ext_q;
  assign rq.rdata = rd_q;

  // ---------------------------------------------------------------
  // pin strobes, registered
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_strobe       <= 1'b0;
      read_n            <= 1'b1;
      write_n           <= 1'b1;
      high_n            <= 1'b1;
      fetch_kind_output <= 1'b0;
      ad_out            <= 16'h0000;
      ad_oe             <= 16'h0000;
    end else if (ce) begin
      addr_strobe       <= 1'b0;
      read_n            <= 1'b1;
      write_n           <= 1'b1;
      high_n            <= 1'b1;
      fetch_kind_output <= 1'b0;
      ad_oe             <= 16'h0000;
      if (ext_q && st_q != EMBC_IDLE) begin
        fetch_kind_output <= !rq.wr && rq.fetch;
        if (st_q == EMBC_ADR) begin
          ad_out <= rq.addr;
          ad_oe  <= 16'hFFFF;
          // latch form pulses in address phase, valid form holds to end
          addr_strobe <= cfg[EMBC_CFG_ADV_BIT] ? 1'b1 : !phase;
        end else begin
          addr_strobe <= cfg[EMBC_CFG_ADV_BIT];
          read_n <= rq.wr;
          if (rq.wr) begin
            ad_out <= ad_odd ? {rq.wdata[7:0], rq.wdata[7:0]} : rq.wdata;
            ad_oe  <= w16_q ? 16'hFFFF : 16'h00FF;
            if (cfg[EMBC_CFG_WRL_BIT]) begin
              write_n <= !use_lo;
            end else begin
              write_n <= 1'b0;
            end
            if (cfg[EMBC_CFG_WRH_BIT]) begin
              high_n <= !ad_odd;
            end else begin
              high_n <= !use_hi;
            end
          end
        end
      end
    end
  end

  property p_rd_int;
    @(posedge pclk) disable iff (!presetn) (!ext_q || rq.wr) |=> read_n;
  endproperty
  a_p_rd_int : assert property (p_rd_int) else $error("read strobe off external read");
endmodule : embc_cycle

/* core/embc_top.sv */
`timescale 1ns/1ns
module embc_top
  import embc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             clock_output,
  input  wire logic        reset_in,
  output logic             reset_out,
  output logic             reset_oe,
  input  wire logic        width_select,
  input  wire logic        external_access_select,
  input  wire logic        ready_in,
  input  wire logic [15:0] ad_in,
  output logic [15:0]      ad_out,
  output logic [15:0]      ad_oe,
  output logic             address_valid_strobe,
  output logic             read_n,
  output logic             write_n,
  output logic             high_byte_n,
  output logic             fetch_kind_output,
  output logic             core_reset
);
  embc_req_if rq ();
  logic [31:0] cfg_q;
  logic        div_q;
  logic [2:0]  rst_sy_q;
  logic [2:0]  rdy_sy_q;
  logic [2:0]  bw_sy_q;
  logic [2:0]  ea_sy_q;
  logic        rst_lvl_q;
  logic        rdy_lvl_q;
  logic        bw_lvl_q;
  logic        ea_lvl_q;
  logic [4:0]  seq_q;
  logic        start_q;
  logic        wr_q;
  logic        fetch_q;
  logic        word_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic        done_q;
  logic        busy_d1_q;
  logic        wr_acc;
  logic [4:0]  oe_hist_q;
  logic        ext_rst;
  logic        run;
  logic        phase;

  // ---------------------------------------------------------------
  // pin synchronisers, change counts when stages 2 and 3 agree
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sy_q  <= 3'b111;
      rdy_sy_q  <= 3'b111;
      bw_sy_q   <= 3'b000;
      ea_sy_q   <= 3'b000;
      rst_lvl_q <= 1'b1;
      rdy_lvl_q <= 1'b1;
      bw_lvl_q  <= 1'b0;
      ea_lvl_q  <= 1'b0;
    end else if (ce) begin
      rst_sy_q <= {rst_sy_q[1:0], reset_in};
      rdy_sy_q <= {rdy_sy_q[1:0], ready_in};
      bw_sy_q  <= {bw_sy_q[1:0], width_select};
      ea_sy_q  <= {ea_sy_q[1:0], external_access_select};
      if (rst_sy_q[1] == rst_sy_q[2]) rst_lvl_q <= rst_sy_q[2];
      if (rdy_sy_q[1] == rdy_sy_q[2]) rdy_lvl_q <= rdy_sy_q[2];
      if (bw_sy_q[1] == bw_sy_q[2]) bw_lvl_q <= bw_sy_q[2];
      if (ea_sy_q[1] == ea_sy_q[2]) ea_lvl_q <= ea_sy_q[2];
    end
  end

  // ---------------------------------------------------------------
  // clock output divider and reset sequence
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 1'b0;
    end else if (ce) begin
      div_q <= ext_rst ? 1'b0 : !div_q;
    end
  end
  assign clock_output = div_q;
  assign phase = div_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= EMBC_RST_SEQ_CYC;
    end else if (ce) begin
      if (ext_rst) begin
        seq_q <= EMBC_RST_SEQ_CYC;
      end else if (seq_q != 5'h00) begin
        seq_q <= seq_q - 5'h01;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_hist_q <= 5'h1F;
    end else if (ce) begin
      oe_hist_q <= {oe_hist_q[3:0], reset_oe};
    end
  end
  // own pull-down and its synchroniser lag never count as an outside reset
  assign ext_rst = !rst_lvl_q && !reset_oe && (oe_hist_q == 5'h00);
  assign run = (seq_q == 5'h00);
  assign core_reset = !run;
  assign reset_out = 1'b0;
  assign reset_oe  = !run;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= EMBC_CFG_RST;
      start_q <= 1'b0;
      wr_q    <= 1'b0;
      fetch_q <= 1'b0;
      word_q  <= 1'b0;
      addr_q  <= 16'h0000;
      wdata_q <= 16'h0000;
    end else if (ce) begin
      if (rq.busy) begin
        start_q <= 1'b0;
      end
      if (wr_acc && paddr == EMBC_CFG_OFS) cfg_q <= pwdata;
      if (wr_acc && paddr == EMBC_ADDR_OFS) addr_q <= pwdata[15:0];
      if (wr_acc && paddr == EMBC_WDATA_OFS) wdata_q <= pwdata[15:0];
      if (wr_acc && paddr == EMBC_REQ_OFS && !start_q && !rq.busy) begin
        wr_q    <= pwdata[EMBC_REQ_WR_BIT];
        fetch_q <= pwdata[EMBC_REQ_FETCH_BIT];
        word_q  <= pwdata[EMBC_REQ_WORD_BIT];
        start_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_d1_q <= 1'b0;
      done_q    <= 1'b0;
    end else if (ce) begin
      busy_d1_q <= rq.busy;
      if (busy_d1_q && !rq.busy) begin
        done_q <= 1'b1;
      end else if (wr_acc && paddr == EMBC_REQ_OFS) begin
        done_q <= 1'b0;
      end
    end
  end

  always_comb begin
    case (paddr)
      EMBC_CFG_OFS:   prdata = cfg_q;
      EMBC_STAT_OFS:  prdata = {26'h0, rq.internal, bw_lvl_q, done_q,
                                start_q | rq.busy, !run, rdy_lvl_q};
      EMBC_REQ_OFS:   prdata = {29'h0, word_q, fetch_q, wr_q};
      EMBC_ADDR_OFS:  prdata = {16'h0, addr_q};
      EMBC_WDATA_OFS: prdata = {16'h0, wdata_q};
      EMBC_RDATA_OFS: prdata = {16'h0, rq.rdata};
      default:        prdata = 32'h0000_0000;
    endcase
  end

  assign rq.start = start_q;
  assign rq.wr    = wr_q;
  assign rq.fetch = fetch_q;
  assign rq.word  = word_q;
  assign rq.addr  = addr_q;
  assign rq.wdata = wdata_q;

  embc_cycle u_cycle (
    .pclk              (pclk),
    .presetn           (presetn),
    .ce                (ce),
    .run               (run),
    .phase             (phase),
    .cfg               (cfg_q),
    .ready_s           (rdy_lvl_q),
    .width_s           (bw_lvl_q),
    .ext_sel_s         (ea_lvl_q),
    .ad_in             (ad_in),
    .rq                (rq),
    .ad_out            (ad_out),
    .ad_oe             (ad_oe),
    .addr_strobe       (address_valid_strobe),
    .read_n            (read_n),
    .write_n           (write_n),
    .high_n            (high_byte_n),
    .fetch_kind_output (fetch_kind_output)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_clk_half;
    @(posedge pclk) disable iff (!presetn)
      (ce && !ext_rst) |=> (clock_output != $past(clock_output));
  endproperty
  a_p_clk_half : assert property (p_clk_half) else $error("clock output not toggling");

  property p_rst_hold;
    @(posedge pclk) disable iff (!presetn) ext_rst |=> !run && reset_oe;
  endproperty
  a_p_rst_hold : assert property (p_rst_hold) else $error("reset not held");

  property p_rst_realign;
    @(posedge pclk) disable iff (!presetn) ext_rst && ce |=> !clock_output;
  endproperty
  a_p_rst_realign : assert property (p_rst_realign) else $error("clock not realigned");

  property p_read_only_rd;
    @(posedge pclk) disable iff (!presetn)
      !read_n |-> !wr_q && (rq.busy || $past(rq.busy));
  endproperty
  a_p_read_only_rd : assert property (p_read_only_rd) else $error("read strobe on write");

  property p_wr_only;
    @(posedge pclk) disable iff (!presetn) !write_n |-> wr_q && !rq.internal;
  endproperty
  a_p_wr_only : assert property (p_wr_only) else $error("write strobe misuse");

  property p_strobe_ext;
    @(posedge pclk) disable iff (!presetn) address_valid_strobe |-> !rq.internal;
  endproperty
  a_p_strobe_ext : assert property (p_strobe_ext) else $error("strobe on internal");

  property p_fetch_ext;
    @(posedge pclk) disable iff (!presetn) fetch_kind_output |-> !rq.internal && fetch_q;
  endproperty
  a_p_fetch_ext : assert property (p_fetch_ext) else $error("fetch kind misuse");

  property p_wrh_odd;
    @(posedge pclk) disable iff (!presetn)
      (!high_byte_n && cfg_q[EMBC_CFG_WRH_BIT]) |-> addr_q[0];
  endproperty
  a_p_wrh_odd : assert property (p_wrh_odd) else $error("high write on even");
endmodule : embc_top

/* test/embc_mem_model.sv */
`timescale 1ns/1ns
module embc_mem_model (
  input  wire logic        pclk,
  input  wire logic [15:0] ad_out,
  input  wire logic [15:0] ad_oe,
  input  wire logic        address_valid_strobe,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        high_byte_n,
  input  wire logic        fetch_kind_output,
  input  wire logic [3:0]  stall,
  output logic [15:0]      ad_in,
  output logic             ready_in
);
  // ---------------------------------------------------------------
  // external memory with latched address
  // ---------------------------------------------------------------
  logic [15:0] mem [16];
  logic [15:0] addr_q;
  logic [3:0]  hold_q = 4'h0;
  logic        rd_p = 1'h1;
  logic        wr_p = 1'h1;
  logic        hb_p = 1'h1;
  logic        as_p = 1'h0;
  int          rd_cnt, wr_cnt, hb_cnt, as_cnt, rd_len, cur_len, kind;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
  end
  always @(posedge pclk) begin
    if (address_valid_strobe && ad_oe != 16'h0000 && read_n && write_n) addr_q <= ad_out;
    if (!write_n) mem[addr_q[4:1]] <= ad_out;
    if (address_valid_strobe && !as_p) hold_q <= 4'h0;
    else if (hold_q != 4'hF) hold_q <= hold_q + 4'h1;
    cur_len <= read_n ? 0 : cur_len + 1;
    if (!read_n) kind <= int'(fetch_kind_output);
    if (read_n && !rd_p) rd_len <= cur_len;
    if (!read_n && rd_p) rd_cnt <= rd_cnt + 1;
    if (!write_n && wr_p) wr_cnt <= wr_cnt + 1;
    if (!high_byte_n && hb_p) hb_cnt <= hb_cnt + 1;
    if (address_valid_strobe && !as_p) as_cnt <= as_cnt + 1;
    rd_p <= read_n;
    wr_p <= write_n;
    hb_p <= high_byte_n;
    as_p <= address_valid_strobe;
  end
  // released bus floats to the pull-up level
  assign ad_in = read_n ? 16'hFFFF : mem[addr_q[4:1]];
  // not ready for stall cycles from each address strobe, ready when idle
  assign ready_in = hold_q >= stall;
endmodule : embc_mem_model

/* test/test_embc_top.sv */
`timescale 1ns/1ns
module test_embc_top;
  import embc_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, st;
  logic        pready, pslverr, clock_output, reset_out, reset_oe, core_reset, prev;
  logic        rst_drv_n = 1'h1;
  logic        width_select = 1'h1;
  logic        external_access_select = 1'h0;
  logic        ready_in, address_valid_strobe, read_n, write_n, high_byte_n, fetch_kind_output;
  logic [15:0] ad_in, ad_out, ad_oe;
  logic [3:0]  stall = 4'h0;
  int          error_cnt, n_checks, cyc, n, l0, b_rd, b_wr, b_hb, b_as;
  always #10 pclk = ~pclk;
  embc_top embc_top_fetch_kind_output (
    .pclk, .presetn, .ce(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clock_output, .reset_in(rst_drv_n & ~reset_oe), .reset_out,
    .reset_oe, .width_select, .external_access_select, .ready_in, .ad_in, .ad_out,
    .ad_oe, .address_valid_strobe, .read_n, .write_n, .high_byte_n, .fetch_kind_output,
    .core_reset);
  embc_mem_model embc_mem_model_fetch_kind_output (
    .pclk, .ad_out, .ad_oe, .address_valid_strobe, .read_n, .write_n, .high_byte_n,
    .fetch_kind_output, .stall, .ad_in, .ready_in);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic ext(input logic [15:0] a, input logic [15:0] d, input logic [2:0] req);
    apb(1'h1, EMBC_ADDR_OFS, 32'(a));
    apb(1'h1, EMBC_WDATA_OFS, 32'(d));
    apb(1'h1, EMBC_REQ_OFS, 32'(req));
    repeat (4) @(posedge pclk);
    n = 0;
    do begin
      apb(1'h0, EMBC_STAT_OFS, 32'h0);
      n++;
    end while ((rd[3] !== 1'h1 || rd[2] !== 1'h0) && n < 300);
    st = rd;
    apb(1'h0, EMBC_RDATA_OFS, 32'h0);
  endtask : ext
  function automatic logic [31:0] dlt;
    dlt = {8'(embc_mem_model_fetch_kind_output.rd_cnt - b_rd), 8'(embc_mem_model_fetch_kind_output.wr_cnt - b_wr),
           8'(embc_mem_model_fetch_kind_output.hb_cnt - b_hb), 8'(embc_mem_model_fetch_kind_output.as_cnt - b_as)};
  endfunction : dlt
  task automatic probe(input logic [15:0] a, input logic [2:0] req, input logic [31:0] e);
    b_rd = embc_mem_model_fetch_kind_output.rd_cnt;
    b_wr = embc_mem_model_fetch_kind_output.wr_cnt;
    b_hb = embc_mem_model_fetch_kind_output.hb_cnt;
    b_as = embc_mem_model_fetch_kind_output.as_cnt;
    ext(a, 16'hA5C3, req);
    chk(dlt(), e);
  endtask : probe
  task automatic count_oe;
    n = 0;
    repeat (60) begin
      @(posedge pclk);
      if (reset_oe === 1'h1) n++;
    end
  endtask : count_oe
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    count_oe();
    chk(n, 20);
    chk(reset_out, 1'h0);
    l0 = 0;
    n = 0;
    prev = clock_output;
    repeat (16) begin
      @(posedge pclk);
      l0 += int'(clock_output);
      n += int'(clock_output != prev);
      prev = clock_output;
    end
    chk(l0, 8);
    chk(n, 16);
    $display("test reset and clock done");
    apb(1'h0, EMBC_CFG_OFS, 32'h0);
    chk(rd, EMBC_CFG_RST);
    apb(1'h0, 12'hFFC, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, EMBC_CFG_OFS, 32'h02);
    apb(1'h0, EMBC_CFG_OFS, 32'h0);
    chk(rd, 32'h02);
    $display("test registers done");
    probe(16'h0104, 3'h5, 32'h00010101);
    chk(st[4], 1'h1);
    probe(16'h0104, 3'h4, 32'h01000001);
    chk(rd, 32'h0000A5C3);
    chk(embc_mem_model_fetch_kind_output.kind, 0);
    probe(16'h0104, 3'h6, 32'h01000001);
    chk(embc_mem_model_fetch_kind_output.kind, 1);
    width_select <= 1'h0;
    probe(16'h0104, 3'h5, 32'h00010001);
    chk(st[4], 1'h0);
    apb(1'h1, EMBC_CFG_OFS, 32'h00);
    width_select <= 1'h1;
    probe(16'h0104, 3'h5, 32'h00010001);
    chk(st[4], 1'h1);
    $display("test width done");
    apb(1'h1, EMBC_CFG_OFS, 32'h0E);
    probe(16'h0109, 3'h1, 32'h00000101);
    probe(16'h0108, 3'h1, 32'h00010001);
    $display("test byte strobes done");
    apb(1'h1, EMBC_CFG_OFS, 32'h02);
    external_access_select <= 1'h1;
    probe(16'h2000, 3'h6, 32'h0);
    chk(rd, 32'h0000FFFF);
    chk(st[5], 1'h1);
    probe(16'h3FFF, 3'h4, 32'h0);
    chk(st[5], 1'h1);
    probe(16'h4000, 3'h4, 32'h01000001);
    chk(st[5], 1'h0);
    external_access_select <= 1'h0;
    probe(16'h2000, 3'h4, 32'h01000001);
    $display("test routing done");
    ext(16'h0104, 16'h0, 3'h4);
    l0 = embc_mem_model_fetch_kind_output.rd_len;
    apb(1'h1, EMBC_CFG_OFS, 32'h32);
    ext(16'h0104, 16'h0, 3'h4);
    chk(embc_mem_model_fetch_kind_output.rd_len - l0, 6);
    apb(1'h1, EMBC_CFG_OFS, 32'h22);
    ext(16'h0104, 16'h0, 3'h4);
    l0 = embc_mem_model_fetch_kind_output.rd_len;
    stall <= 4'hC;
    ext(16'h0104, 16'h0, 3'h4);
    chk(rd, 32'h0000A5C3);
    chk(32'(embc_mem_model_fetch_kind_output.rd_len > l0), 32'h1);
    stall <= 4'h0;
    apb(1'h1, EMBC_CFG_OFS, 32'h03);
    probe(16'h0104, 3'h4, 32'h01000001);
    chk(rd, 32'h0000A5C3);
    $display("test timing and strobe form done");
    rst_drv_n <= 1'h0;
    repeat (8) @(posedge pclk);
    chk(clock_output, 1'h0);
    rst_drv_n <= 1'h1;
    count_oe();
    chk(n, 17);
    $display("test pin reset done");
    close_out();
  end
endmodule : test_embc_top
